// ===== src/smc_pkg.sv
// package of constants and types for the sleep mode controller
// Operation
// [R1] active plus idle, standby, power down modes
// [R2] core writes mode, enable, then sleeps
// [R3] sleep needs enable bit already set
// [R4] mode codes: idle 0, standby 1, power_down_mode 2
// [R5] mode latched at sleep instruction time
// [R6] sleep halts cpu, gates unused domains
// [R7] wake interrupt returns to active mode
// [R8] any reset leaves every sleep mode
// [R9] debug break wakes without pending interrupt
// [R10] software enables some wake interrupt first
// [R11] idle stops only cpu, all wake
// [R12] standby runs peripherals per run bit
// [R13] standby wake sources, conditional by run bit
// [R14] conditional entries need run-in-standby bit
// [R15] power down keeps watchdog and periodic timer
// [R16] power down wakes by pin, i2c match
// [R17] power down stops all but low-power clocks
// [R18] wake latency six cycles plus oscillator start
// [R19] idle wake exactly base cycles
// [R20] brown-out config 3 waits detector ready
// [R21] reserved mode code keeps device active
package smc_pkg;
   localparam logic [7:0] SMC_ADDR_CTRL = 8'h00;
   localparam logic [7:0] SMC_ADDR_STBY = 8'h04;
   localparam logic [7:0] SMC_ADDR_STAT = 8'h08;
   localparam logic [7:0] SMC_CTRL_RESET = 8'h00;
   localparam int SMC_EN_BIT = 0;
   localparam int SMC_MODE_LSB = 1;
   localparam logic [1:0] SMC_MODE_IDLE = 2'h0;
   localparam logic [1:0] SMC_MODE_STBY = 2'h1;
   localparam logic [1:0] SMC_MODE_POWER_DOWN_MODE = 2'h2;
   localparam logic [1:0] SMC_MODE_RSVD = 2'h3;
   localparam logic [1:0] SMC_BOD_WAIT = 2'h3;
   localparam logic [3:0] SMC_BASE_WAKE = 4'h6;
   // run-in-standby bit positions
   localparam int SMC_RS_RTC = 0;
   localparam int SMC_RS_ADC = 1;
   localparam int SMC_RS_UART = 2;
   localparam int SMC_RS_OSC = 3;
   localparam int SMC_RS_W = 4;
   typedef enum logic [3:0] {
      SMC_ACTIVE = 4'b0001,
      SMC_SLEEP = 4'b0010,
      SMC_OSCUP = 4'b0100,
      SMC_WAKE = 4'b1000
   } smc_state_t;
   typedef struct packed {
      logic pin;
      logic i2c_match;
      logic uart_sof;
      logic adc_win;
      logic rtc;
      logic periodic_interrupt_timer;
      logic timer_b;
      logic other;
   } smc_wake_t;
   typedef struct packed {
      logic cpu;
      logic per;
      logic rtc;
      logic adc;
      logic periodic_interrupt_timer;
      logic wdt;
      logic main_osc;
      logic rtc_osc;
   } smc_gate_t;
endpackage

// ===== src/smc_sleep_controller.sv
// sleep controller: apb registers, sleep state machine, clock gating
`timescale 1ns/100ps
module smc_sleep_controller import smc_pkg::*; #(
   // wake count in peripheral clocks, kept tunable for faster cores
   parameter logic [3:0] BASE_WAKE = SMC_BASE_WAKE
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep_instr,
   input wire smc_wake_t wake_req,
   input wire logic debug_break,
   input wire logic [1:0] brown_out_config_fuse,
   input wire logic bod_ready,
   input wire logic osc_stable,
   output smc_gate_t clk_run_q,
   output logic cpu_halt_q,
   output logic wake_done_q
);
   ////////////////////////////////////////////////////////////////
   logic [7:0] ctrl_q;
   logic [SMC_RS_W-1:0] stby_q;
   smc_state_t state_q;
   logic [1:0] mode_q;
   logic [3:0] cnt_q;
   logic [1:0] bod_s_q;
   logic [1:0] osc_s_q;
   logic [1:0] dbg_s_q;
   logic [7:0] wake_s1_q;
   logic [7:0] wake_s2_q;
   logic access;
   logic mapped;
   logic wake_hit;
   logic osc_was_off;
   smc_wake_t w;
   smc_gate_t gate;

   assign access = psel && penable;
   assign mapped = (paddr == SMC_ADDR_CTRL) || (paddr == SMC_ADDR_STBY) || (paddr == SMC_ADDR_STAT);

   ////////////////////////////////////////////////////////////////
   // async inputs pass two flops before use
   always_ff @(posedge clk) begin
      if (!nrst) begin
         bod_s_q <= 2'h0;
      end else begin
         bod_s_q <= {bod_s_q[0], bod_ready};
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         osc_s_q <= 2'h0;
      end else begin
         osc_s_q <= {osc_s_q[0], osc_stable};
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         dbg_s_q <= 2'h0;
      end else begin
         dbg_s_q <= {dbg_s_q[0], debug_break};
      end
   end

   // first stage read only by the second: no metastable fan-out
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wake_s1_q <= 8'h00;
         wake_s2_q <= 8'h00;
      end else begin
         wake_s1_q <= wake_req;
         wake_s2_q <= wake_s1_q;
      end
   end
   assign w = smc_wake_t'(wake_s2_q);

   ////////////////////////////////////////////////////////////////
   // apb slave, zero wait states
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctrl_q <= SMC_CTRL_RESET; // [R8]
         stby_q <= '0;
      end else if (access && pwrite) begin
         if (paddr == SMC_ADDR_CTRL) begin
            ctrl_q <= {5'h00, pwdata[2:0]};
         end
         if (paddr == SMC_ADDR_STBY) begin
            stby_q <= pwdata[SMC_RS_W-1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable ? 1'b0 : psel;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel && !penable) begin
            pready <= 1'b1;
            pslverr <= !mapped;
            if (paddr == SMC_ADDR_CTRL) begin
               prdata <= {24'h000000, ctrl_q};
            end else if (paddr == SMC_ADDR_STBY) begin
               prdata <= {28'h0000000, stby_q};
            end else if (paddr == SMC_ADDR_STAT) begin
               prdata <= {26'h0, mode_q, state_q};
            end
         end else begin
            pready <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // wake source qualification per latched mode
   always_comb begin
      case (mode_q)
         SMC_MODE_IDLE: wake_hit = |wake_s2_q; // [R11]
         SMC_MODE_STBY: wake_hit = w.pin || w.i2c_match || w.periodic_interrupt_timer || w.timer_b
            || (w.uart_sof && stby_q[SMC_RS_UART]) || (w.adc_win && stby_q[SMC_RS_ADC])
            || (w.rtc && stby_q[SMC_RS_RTC]); // [R13] [R14]
         SMC_MODE_POWER_DOWN_MODE: wake_hit = w.pin || w.i2c_match; // [R16]
         default: wake_hit = 1'b0;
      endcase
   end

   // idle keeps main clock; standby keeps it only if its run bit set
   assign osc_was_off = (mode_q == SMC_MODE_POWER_DOWN_MODE)
      || (mode_q == SMC_MODE_STBY && !stby_q[SMC_RS_OSC]); // [R19]

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q <= SMC_ACTIVE; // [R8]
         mode_q <= SMC_MODE_IDLE;
         cnt_q <= 4'h0;
         wake_done_q <= 1'b0;
      end else begin
         wake_done_q <= 1'b0;
         case (state_q)
            SMC_ACTIVE: begin
               // reserved code is ignored and execution carries on
               if (sleep_instr && ctrl_q[SMC_EN_BIT]
                  && ctrl_q[SMC_MODE_LSB +: 2] != SMC_MODE_RSVD) begin // [R3] [R21]
                  mode_q <= ctrl_q[SMC_MODE_LSB +: 2]; // [R5] [R4]
                  state_q <= SMC_SLEEP; // [R6]
               end
            end
            SMC_SLEEP: begin
               if (wake_hit || dbg_s_q[1]) begin // [R7] [R9]
                  cnt_q <= 4'h0;
                  state_q <= osc_was_off ? SMC_OSCUP : SMC_WAKE;
               end
            end
            SMC_OSCUP: begin
               if (osc_s_q[1]) begin // [R18]
                  state_q <= SMC_WAKE;
               end
            end
            SMC_WAKE: begin
               if (cnt_q != BASE_WAKE) begin
                  cnt_q <= cnt_q + 4'h1; // [R18]
               end
               // detector ready sooner keeps the base latency
               if ((cnt_q + 4'h1 >= BASE_WAKE)
                  && (brown_out_config_fuse != SMC_BOD_WAIT || bod_s_q[1])) begin // [R20]
                  state_q <= SMC_ACTIVE; // [R7]
                  wake_done_q <= 1'b1;
               end
            end
            default: state_q <= SMC_ACTIVE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // clock domain gating per mode [R1]
   always_comb begin
      gate = '1;
      if (state_q == SMC_SLEEP || state_q == SMC_OSCUP) begin
         gate.cpu = 1'b0; // [R6]
         case (mode_q)
            SMC_MODE_IDLE: gate.cpu = 1'b0; // [R11]
            SMC_MODE_STBY: begin
               gate.per = 1'b0; // [R12]
               gate.rtc = stby_q[SMC_RS_RTC]; // [R14]
               gate.adc = stby_q[SMC_RS_ADC];
               gate.main_osc = stby_q[SMC_RS_OSC] || state_q == SMC_OSCUP;
               gate.rtc_osc = stby_q[SMC_RS_RTC];
            end
            default: begin
               gate.per = 1'b0; // [R15]
               gate.rtc = 1'b0;
               gate.adc = 1'b0;
               gate.main_osc = state_q == SMC_OSCUP; // [R17]
               gate.rtc_osc = 1'b1;
            end
         endcase
      end else if (state_q == SMC_WAKE) begin
         gate.cpu = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         clk_run_q <= '1;
         cpu_halt_q <= 1'b0;
      end else begin
         clk_run_q <= gate;
         cpu_halt_q <= !gate.cpu; // [R6]
      end
   end

   ////////////////////////////////////////////////////////////////
   sequence s_wake_seen;
      state_q == SMC_SLEEP && (wake_hit || dbg_s_q[1]);
   endsequence

   a_no_sleep_off: assert property (@(posedge clk) disable iff (!nrst) // [R3]
      state_q == SMC_ACTIVE && sleep_instr && !ctrl_q[SMC_EN_BIT] |=> state_q == SMC_ACTIVE)
      else $error("slept without enable");
   a_reserved_stay: assert property (@(posedge clk) disable iff (!nrst) // [R21]
      state_q == SMC_ACTIVE && ctrl_q[2:1] == 2'h3 |=> state_q == SMC_ACTIVE)
      else $error("reserved mode entered sleep");
   a_mode_latch: assert property (@(posedge clk) disable iff (!nrst) // [R5]
      state_q == SMC_ACTIVE && sleep_instr && ctrl_q[0] && ctrl_q[2:1] != 2'h3
      |=> state_q == SMC_SLEEP && mode_q == $past(ctrl_q[2:1]))
      else $error("mode not latched");
   a_cpu_halted: assert property (@(posedge clk) disable iff (!nrst) // [R6]
      state_q == SMC_SLEEP |=> cpu_halt_q)
      else $error("cpu runs in sleep");
   a_idle_latency: assert property (@(posedge clk) disable iff (!nrst) // [R19]
      s_wake_seen ##0 mode_q == SMC_MODE_IDLE && brown_out_config_fuse != 2'h3
      |=> state_q == SMC_WAKE [*6] ##1 state_q == SMC_ACTIVE)
      else $error("idle wake not six cycles");
   a_power_down_mode_wake: assert property (@(posedge clk) disable iff (!nrst) // [R16]
      state_q == SMC_SLEEP && mode_q == SMC_MODE_POWER_DOWN_MODE && !w.pin && !w.i2c_match && !dbg_s_q[1]
      |=> state_q == SMC_SLEEP)
      else $error("power down woke by other source");
   a_power_down_mode_gates: assert property (@(posedge clk) disable iff (!nrst) // [R15]
      state_q == SMC_SLEEP && mode_q == SMC_MODE_POWER_DOWN_MODE |=> !clk_run_q.per && clk_run_q.wdt && clk_run_q.periodic_interrupt_timer)
      else $error("power down gating wrong");
   a_bod_wait: assert property (@(posedge clk) disable iff (!nrst) // [R20]
      state_q == SMC_WAKE && brown_out_config_fuse == 2'h3 && !bod_s_q[1] |=> state_q != SMC_ACTIVE)
      else $error("woke before detector ready");
   a_debug_wake: assert property (@(posedge clk) disable iff (!nrst) // [R9]
      state_q == SMC_SLEEP && dbg_s_q[1] |=> state_q != SMC_SLEEP)
      else $error("debug break did not wake");

   ////////////////////////////////////////////////////////////////
   // entry and wake steps
   sequence s_sleep_taken;
      state_q == SMC_ACTIVE && sleep_instr && ctrl_q[SMC_EN_BIT] && ctrl_q[SMC_MODE_LSB +: 2] != SMC_MODE_RSVD;
   endsequence
   sequence s_wake_entry;
      state_q != SMC_WAKE ##1 state_q == SMC_WAKE;
   endsequence
   sequence s_wake_exit;
      state_q == SMC_WAKE ##1 state_q == SMC_ACTIVE;
   endsequence

   a_halt_follows: assert property (@(posedge clk) disable iff (!nrst) // [R6]
      s_sleep_taken
      |=> ##1 cpu_halt_q && !clk_run_q.cpu)
      else $error("cpu not halted after sleep entry");
   a_wake_min: assert property (@(posedge clk) disable iff (!nrst) // [R18]
      s_wake_entry
      |-> state_q == SMC_WAKE [*6])
      else $error("wake count cut short");
   a_wake_pulse: assert property (@(posedge clk) disable iff (!nrst) // [R7]
      s_wake_exit
      |-> wake_done_q)
      else $error("no wake done pulse");
   a_done_single: assert property (@(posedge clk) disable iff (!nrst) // [R7]
      wake_done_q
      |=> !wake_done_q)
      else $error("wake done pulse too long");
   a_halt_waking: assert property (@(posedge clk) disable iff (!nrst) // [R6]
      state_q == SMC_WAKE
      |=> cpu_halt_q)
      else $error("cpu released during wake count");
   a_active_run: assert property (@(posedge clk) disable iff (!nrst) // [R7]
      state_q == SMC_ACTIVE
      |=> !cpu_halt_q && (&clk_run_q))
      else $error("domain gated while active");

   ////////////////////////////////////////////////////////////////
   // per mode gating and wake qualification
   a_idle_gates: assert property (@(posedge clk) disable iff (!nrst) // [R11]
      state_q == SMC_SLEEP && mode_q == SMC_MODE_IDLE
      |=> !clk_run_q.cpu && clk_run_q.per && clk_run_q.rtc && clk_run_q.adc && clk_run_q.main_osc)
      else $error("idle gated a peripheral");
   a_idle_any: assert property (@(posedge clk) disable iff (!nrst) // [R11]
      state_q == SMC_SLEEP && mode_q == SMC_MODE_IDLE && (|wake_s2_q)
      |=> state_q == SMC_WAKE)
      else $error("idle ignored a wake source");
   a_stby_run: assert property (@(posedge clk) disable iff (!nrst) // [R12] [R14]
      state_q == SMC_SLEEP && mode_q == SMC_MODE_STBY
      |=> !clk_run_q.per && clk_run_q.rtc == $past(stby_q[SMC_RS_RTC]) && clk_run_q.adc == $past(stby_q[SMC_RS_ADC]))
      else $error("standby gating ignores run bits");
   a_stby_wake: assert property (@(posedge clk) disable iff (!nrst) // [R13]
      state_q == SMC_SLEEP && mode_q == SMC_MODE_STBY && (w.pin || w.i2c_match || w.periodic_interrupt_timer || w.timer_b)
      |=> state_q != SMC_SLEEP)
      else $error("standby missed a wake source");
   a_stby_cond: assert property (@(posedge clk) disable iff (!nrst) // [R14]
      state_q == SMC_SLEEP && mode_q == SMC_MODE_STBY && !stby_q[SMC_RS_UART] && !w.pin && !w.i2c_match
      && !w.periodic_interrupt_timer && !w.timer_b && !w.adc_win && !w.rtc && !dbg_s_q[1]
      |=> state_q == SMC_SLEEP)
      else $error("standby woke by stopped source");
   a_power_down_mode_osc: assert property (@(posedge clk) disable iff (!nrst) // [R17]
      state_q == SMC_SLEEP && mode_q == SMC_MODE_POWER_DOWN_MODE
      |=> !clk_run_q.main_osc && !clk_run_q.rtc && !clk_run_q.adc && !clk_run_q.cpu)
      else $error("power down left a clock running");
   a_power_down_mode_pin: assert property (@(posedge clk) disable iff (!nrst) // [R16]
      state_q == SMC_SLEEP && mode_q == SMC_MODE_POWER_DOWN_MODE && (w.pin || w.i2c_match)
      |=> state_q == SMC_OSCUP)
      else $error("power down missed pin wake");

   ////////////////////////////////////////////////////////////////
   // oscillator and detector waits
   a_osc_hold: assert property (@(posedge clk) disable iff (!nrst) // [R18]
      state_q == SMC_OSCUP && !osc_s_q[1]
      |=> state_q == SMC_OSCUP)
      else $error("left oscillator wait early");
   a_osc_done: assert property (@(posedge clk) disable iff (!nrst) // [R18]
      state_q == SMC_OSCUP && osc_s_q[1]
      |=> state_q == SMC_WAKE)
      else $error("oscillator ready but no wake count");
   a_bod_release: assert property (@(posedge clk) disable iff (!nrst) // [R20]
      state_q == SMC_WAKE && cnt_q == BASE_WAKE && bod_s_q[1]
      |=> state_q == SMC_ACTIVE)
      else $error("detector ready but still waking");

   ////////////////////////////////////////////////////////////////
   // mode hold, reset and register access
   a_mode_frozen: assert property (@(posedge clk) disable iff (!nrst) // [R5]
      state_q != SMC_ACTIVE
      |=> mode_q == $past(mode_q))
      else $error("mode changed while asleep");
   a_no_rsvd_mode: assert property (@(posedge clk) disable iff (!nrst) // [R4]
      state_q != SMC_ACTIVE
      |-> mode_q != SMC_MODE_RSVD)
      else $error("asleep in reserved mode");
   a_state_onehot: assert property (@(posedge clk) disable iff (!nrst) // [R1]
      $onehot(state_q))
      else $error("state not one hot");
   a_reset_exit: assert property (@(posedge clk) // [R8]
      !nrst
      |=> state_q == SMC_ACTIVE && ctrl_q == SMC_CTRL_RESET && !cpu_halt_q)
      else $error("reset did not leave sleep");
   a_ctrl_write: assert property (@(posedge clk) disable iff (!nrst) // [R4]
      psel && penable && pwrite && paddr == SMC_ADDR_CTRL
      |=> ctrl_q == {5'h00, $past(pwdata[2:0])})
      else $error("control write lost");
   a_setup_ready: assert property (@(posedge clk) disable iff (!nrst) // [R4]
      psel && !penable
      |=> pready)
      else $error("no ready in access cycle");
   a_slverr_map: assert property (@(posedge clk) disable iff (!nrst) // [R4]
      psel && !penable && paddr > SMC_ADDR_STAT
      |=> pready && pslverr)
      else $error("unmapped access not refused");
endmodule // smc_sleep_controller

// ===== verif/smc_core_model.sv
// core model: issues the sleep instruction and holds wake requests
`timescale 1ns/100ps
module smc_core_model import smc_pkg::*; (
   input wire logic clk,
   output logic sleep_instr,
   output smc_wake_t wake_req
);
   initial begin
      sleep_instr = 1'b0;
      wake_req = smc_wake_t'(8'h00);
   end
   ////////////////////////////////////////////////////////////////
   // only called after the control write has completed
   task automatic do_sleep();
      @(posedge clk);
      sleep_instr <= 1'b1;
      @(posedge clk);
      sleep_instr <= 1'b0;
   endtask
   // level request, held until the bench drops it
   task automatic raise(input logic [7:0] w);
      @(posedge clk);
      wake_req <= smc_wake_t'(w);
   endtask
endmodule // smc_core_model

// ===== verif/tb_sleep_mode_controller.sv
// testbench of the sleep mode controller
`timescale 1ns/100ps
module tb_sleep_mode_controller import smc_pkg::*;;
   logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, debug_break = 1'b0;
   logic bod_ready = 1'b1, osc_stable = 1'b1, pready, pslverr, sleep_instr, cpu_halt_q, wake_done_q, e;
   logic [1:0] fuse = 2'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   smc_wake_t wake_req;
   smc_gate_t clk_run_q;
   int mismatches = 0, tests_run = 0;
   always #12.5 clk = ~clk;
   smc_sleep_controller DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sleep_instr(sleep_instr), .wake_req(wake_req), .debug_break(debug_break),
      .brown_out_config_fuse(fuse), .bod_ready(bod_ready), .osc_stable(osc_stable),
      .clk_run_q(clk_run_q), .cpu_halt_q(cpu_halt_q), .wake_done_q(wake_done_q));
   smc_core_model core (.clk(clk), .sleep_instr(sleep_instr), .wake_req(wake_req));
   ////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("mismatches %0d of %0d compares", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask
   // no cycle count assumed: the watchdog cuts a stuck access
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      check(r, x);
   endtask
   task automatic nap(input logic [7:0] c, input logic [7:0] g, input logic h);
      apb(1'b1, SMC_ADDR_CTRL, {24'h0, c});
      core.do_sleep();
      repeat (4) @(posedge clk);
      check(clk_run_q, {24'h0, g});
      check({31'h0, cpu_halt_q}, {31'h0, h});
   endtask
   // 60 means no wake seen inside the window
   task automatic wk(input logic [7:0] w, input int lo, input int hi);
      int n;
      n = 0;
      core.raise(w);
      while (wake_done_q !== 1'b1 && n < 60) begin
         @(posedge clk);
         n++;
      end
      core.raise(8'h00);
      check({31'h0, n >= lo && n <= hi}, 32'h1);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      check(clk_run_q, 32'hff);
      rd(SMC_ADDR_CTRL, 32'h0);
      rd(SMC_ADDR_STAT, 32'h1);
      apb(1'b1, 8'h0c, 32'h5);
      check({31'h0, e}, 32'h1);
      rd(8'h0c, 32'h0);
      apb(1'b1, SMC_ADDR_STBY, 32'h0);
      nap(8'h04, 8'hff, 1'b0);
      nap(8'h07, 8'hff, 1'b0);
      rd(SMC_ADDR_CTRL, 32'h7);
      nap(8'h01, 8'h7f, 1'b1);
      wk(8'h01, 6, 12);
      osc_stable <= 1'b0;
      nap(8'h03, 8'h0c, 1'b1);
      wk(8'h20, 60, 60);
      wk(8'h02, 60, 60);
      osc_stable <= 1'b1;
      wk(8'h00, 4, 12);
      apb(1'b1, SMC_ADDR_STBY, 32'hf);
      nap(8'h03, 8'h3f, 1'b1);
      wk(8'h10, 6, 12);
      osc_stable <= 1'b0;
      nap(8'h05, 8'h0d, 1'b1);
      wk(8'h21, 60, 60);
      wk(8'h40, 60, 60);
      rd(SMC_ADDR_STAT, 32'h24);
      osc_stable <= 1'b1;
      wk(8'h00, 4, 12);
      nap(8'h01, 8'h7f, 1'b1);
      debug_break <= 1'b1;
      wk(8'h00, 4, 12);
      debug_break <= 1'b0;
      fuse <= 2'h3;
      bod_ready <= 1'b0;
      nap(8'h01, 8'h7f, 1'b1);
      wk(8'h80, 60, 60);
      bod_ready <= 1'b1;
      wk(8'h00, 1, 8);
      fuse <= 2'h0;
      nap(8'h05, 8'h0d, 1'b1);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      check(clk_run_q, 32'hff);
      check({31'h0, cpu_halt_q}, 32'h0);
      rd(SMC_ADDR_CTRL, 32'h0);
      give_verdict();
   end
   // whole run is near 500 cycles
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      give_verdict();
   end
endmodule // tb_sleep_mode_controller
